// *** logic/lcl_cause_latch.sv ***
// Interrupt cause latch with enable mask, auto-mask and delayed tx interrupt
//
// Contract
// [R1] Events set cause bits until cleared
// [R2] Set cause with enabled mask raises interrupt
// [R3] Any event clears delay timers, sets their cause
// [R4] Read with zero mask clears all causes
// [R5] Read while pending clears, applies auto-mask
// [R6] Read while not pending leaves causes
// [R7] Write one clears bit, zero no effect
// [R8] Pending flag ignores writes, drops when clear
// [R9] Vector clear also clears bits 7,16,17
// [R10] Bit 0 on tx report, delayed optionally
// [R11] Bit 1 while any tx queue empty
// [R12] Bit 2 on every link change
// [R13] Bit 4 on rx descriptor low threshold
// [R14] Bit 5 on write-disable control change
// [R15] Bit 6 on rx FIFO overrun
// [R16] Bit 7 on rx timer expiry
// [R17] Bit 9 on management access done
// [R18] Bit 12 on PHY interrupt
// [R19] Bit 31 pending, drives interrupt if enabled
// [R20] Reserved bits always read zero
// [R21] Interrupt is OR of cause AND mask
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module lcl_cause_latch
  import lcl_pkg::*;
(
  input  wire logic              clk,            // 40 MHz MAC clock
  input  wire logic              sys_rst,        // Async reset, active high
  input  wire logic              ce,             // Clock enable, freezes all
  input  wire logic [ADDR_W-1:0] reg_addr,       // Register byte address
  input  wire logic [31:0]       reg_wdata,      // Write data
  input  wire logic              reg_wr,         // Write strobe
  input  wire logic              reg_rd,         // Read strobe
  output var  logic [31:0]       reg_rdata,      // Read data, cycle after strobe
  input  wire lcl_evt_t          evt,            // Same-clock event sources
  input  wire logic [1:0]        tx_queue_empty, // Per-queue empty level
  input  wire logic              cpu_vector_clr, // Processor vector cleared
  input  wire logic              pci_int_en,     // Config space interrupt enable
  input  wire logic              link_up_pin,    // PHY link indication pin
  input  wire logic              phy_int_n_pin,  // PHY interrupt pin, low active
  output var  logic              int_asserted,   // Pending flag
  output var  logic              irq             // Host interrupt request
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic link_meta_ff;       // First stage, read only by second
  logic link_sync_ff;       // Synchronised link level
  logic link_prev_ff;       // Previous link level
  logic phy_meta_ff;        // First stage, read only by second
  logic phy_sync_ff;        // Synchronised PHY interrupt, low active
  logic phy_prev_ff;        // Previous PHY interrupt level
  logic dis_prev_ff;        // Previous write-disable control level
  logic nxt_link_meta;      // Next values
  logic nxt_link_sync;
  logic nxt_link_prev;
  logic nxt_phy_meta;
  logic nxt_phy_sync;
  logic nxt_phy_prev;
  logic nxt_dis_prev;

  // Shift the pins through two stages before any edge logic sees them
  always_comb
  begin
    nxt_link_meta = link_up_pin;
    nxt_link_sync = link_meta_ff;
    nxt_link_prev = link_sync_ff;
    nxt_phy_meta  = phy_int_n_pin;
    nxt_phy_sync  = phy_meta_ff;
    nxt_phy_prev  = phy_sync_ff;
    nxt_dis_prev  = evt.sw_dis_ctrl;
  end

  // Reset the pin history to the idle levels
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      link_meta_ff <= 1'b0;
      link_sync_ff <= 1'b0;
      link_prev_ff <= 1'b0;
      phy_meta_ff  <= 1'b1;
      phy_sync_ff  <= 1'b1;
      phy_prev_ff  <= 1'b1;
      dis_prev_ff  <= 1'b0;
    end
    else if (ce)
    begin
      link_meta_ff <= nxt_link_meta;
      link_sync_ff <= nxt_link_sync;
      link_prev_ff <= nxt_link_prev;
      phy_meta_ff  <= nxt_phy_meta;
      phy_sync_ff  <= nxt_phy_sync;
      phy_prev_ff  <= nxt_phy_prev;
      dis_prev_ff  <= nxt_dis_prev;
    end
  end

  // ************************************************************
  // Event vector
  // ************************************************************
  logic [31:0] ev;          // One bit per cause set this cycle
  logic        tx_fire;     // Bit 0 fires now
  logic        any_other;   // Any event besides a delayed tx request

  // Gather every source into its cause position
  always_comb
  begin
    ev              = ZERO32;
    ev[BIT_TX_DESCRIPTOR_WRITTEN_BACK]    = tx_fire;                          // [R10]
    // Level, so it re-sets after a clear until every queue refills
    ev[BIT_TX_QUEUE_EMPTY]    = |tx_queue_empty;                  // [R11]
    ev[BIT_LSC]     = link_sync_ff ^ link_prev_ff;      // [R12]
    ev[BIT_RXDMT]   = evt.rx_low;                       // [R13]
    ev[BIT_DSW]     = evt.sw_dis_ctrl ^ dis_prev_ff;    // [R14]
    ev[BIT_RXO]     = evt.rx_overrun;                   // [R15]
    ev[BIT_RX_TIMER_EXPIRED]    = evt.rx_timer;                     // [R16]
    ev[BIT_PHY_MGMT_ACCESS_DONE]    = evt.mdio_done;                    // [R17]
    ev[BIT_PHY_INTERRUPT]  = phy_prev_ff & ~phy_sync_ff;       // [R18]
    any_other       = (|(ev & ~(32'h1 << BIT_TX_DESCRIPTOR_WRITTEN_BACK))) |
                      (evt.tx_desc_done & ~evt.tx_delay_req);
  end

  // ************************************************************
  // Delayed tx interrupt timers
  // ************************************************************
  lcl_txst_t   tx_st_ff;    // Timer state
  logic [15:0] tx_interrupt_delay_timer_ff;     // Inter-descriptor delay count
  logic [15:0] tx_absolute_delay_timer_ff;     // Absolute delay count
  lcl_txst_t   nxt_tx_st;
  logic [15:0] nxt_tx_interrupt_delay_timer;
  logic [15:0] nxt_tx_absolute_delay_timer;
  logic [15:0] tx_interrupt_delay_timer_cfg_ff; // Reload values from software
  logic [15:0] tx_absolute_delay_timer_cfg_ff;

  // Run both timers; whichever reaches zero first fires bit 0
  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_interrupt_delay_timer  = tx_interrupt_delay_timer_ff;
    nxt_tx_absolute_delay_timer  = tx_absolute_delay_timer_ff;
    tx_fire   = evt.tx_desc_done & ~evt.tx_delay_req;   // [R10]
    unique case (tx_st_ff)
      LCL_TX_IDLE:
      begin
        if (evt.tx_desc_done && evt.tx_delay_req)
        begin
          // A coincident event cancels the delay at once
          if (any_other)
          begin
            tx_fire = 1'b1;                             // [R3]
          end
          else
          begin
            nxt_tx_st = LCL_TX_WAIT;
            nxt_tx_interrupt_delay_timer  = tx_interrupt_delay_timer_cfg_ff;
            nxt_tx_absolute_delay_timer  = tx_absolute_delay_timer_cfg_ff;
          end
        end
      end
      LCL_TX_WAIT:
      begin
        if (any_other)
        begin
          // Other event: timers cleared, their cause set
          tx_fire   = 1'b1;                             // [R3]
          nxt_tx_st = LCL_TX_IDLE;
        end
        else if (tx_interrupt_delay_timer_ff == 16'h0000 || tx_absolute_delay_timer_ff == 16'h0000)
        begin
          tx_fire   = 1'b1;                             // [R10]
          nxt_tx_st = LCL_TX_IDLE;
        end
        else
        begin
          // New delayed descriptor restarts only the short timer
          nxt_tx_interrupt_delay_timer = (evt.tx_desc_done) ? tx_interrupt_delay_timer_cfg_ff : tx_interrupt_delay_timer_ff - 16'h0001;
          nxt_tx_absolute_delay_timer = tx_absolute_delay_timer_ff - 16'h0001;
        end
      end
      default:
      begin
        // Illegal code recovers to idle
        nxt_tx_st = LCL_TX_IDLE;
      end
    endcase
  end

  // Timer registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_st_ff <= LCL_TX_IDLE;
      tx_interrupt_delay_timer_ff  <= DELAY_RST;
      tx_absolute_delay_timer_ff  <= DELAY_RST;
    end
    else if (ce)
    begin
      tx_st_ff <= nxt_tx_st;
      tx_interrupt_delay_timer_ff  <= nxt_tx_interrupt_delay_timer;
      tx_absolute_delay_timer_ff  <= nxt_tx_absolute_delay_timer;
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0] cause_ff;    // Latched causes
  logic [31:0] mask_ff;     // Enable mask
  logic [31:0] auto_ff;     // Auto-mask value
  logic        pend_ff;     // Pending flag
  logic        irq_ff;      // Host interrupt
  logic [31:0] rdata_ff;    // Read data
  logic [31:0] nxt_cause;
  logic [31:0] nxt_mask;
  logic [31:0] nxt_auto;
  logic [15:0] nxt_tx_interrupt_delay_timer_cfg;
  logic [15:0] nxt_tx_absolute_delay_timer_cfg;
  logic        nxt_pend;
  logic        nxt_irq;
  logic [31:0] nxt_rdata;
  logic        rd_cause;    // Read of the cause register
  logic        wr_cause;    // Write of the cause register

  // Bus decode, clearing actions and cause update
  always_comb
  begin
    nxt_cause    = cause_ff;
    nxt_mask     = mask_ff;
    nxt_auto     = auto_ff;
    nxt_tx_interrupt_delay_timer_cfg = tx_interrupt_delay_timer_cfg_ff;
    nxt_tx_absolute_delay_timer_cfg = tx_absolute_delay_timer_cfg_ff;
    nxt_rdata    = ZERO32;
    rd_cause     = reg_rd & lcl_hit(reg_addr, OFF_CAUSE);
    wr_cause     = reg_wr & lcl_hit(reg_addr, OFF_CAUSE);

    // Read data; bit 31 is the pending flag, unmapped reads return zero
    if (reg_rd)
    begin
      if (rd_cause)
      begin
        nxt_rdata = (cause_ff & CAUSE_IMPL) | {pend_ff, 31'h0}; // [R19] [R20]
      end
      else if (lcl_hit(reg_addr, OFF_MASK))
      begin
        nxt_rdata = mask_ff;
      end
      else if (lcl_hit(reg_addr, OFF_AUTO))
      begin
        nxt_rdata = auto_ff;
      end
      else if (lcl_hit(reg_addr, OFF_TX_INTERRUPT_DELAY_TIMER))
      begin
        nxt_rdata = {16'h0000, tx_interrupt_delay_timer_cfg_ff};
      end
      else if (lcl_hit(reg_addr, OFF_TX_ABSOLUTE_DELAY_TIMER))
      begin
        nxt_rdata = {16'h0000, tx_absolute_delay_timer_cfg_ff};
      end
    end

    // Read side effects chosen by mask and pending state
    if (rd_cause)
    begin
      if (mask_ff == ZERO32)
      begin
        nxt_cause = ZERO32;                             // [R4]
      end
      else if (pend_ff)
      begin
        nxt_cause = ZERO32;                             // [R5]
        nxt_mask  = mask_ff & ~auto_ff;                 // [R5]
      end
      else
      begin
        nxt_cause = cause_ff;                           // [R6]
      end
    end

    // Writes; bit 31 of the cause word is not storage
    if (wr_cause)
    begin
      nxt_cause = nxt_cause & ~reg_wdata;               // [R7] [R8]
    end
    else if (reg_wr && lcl_hit(reg_addr, OFF_MASK))
    begin
      nxt_mask = reg_wdata & CAUSE_IMPL;
    end
    else if (reg_wr && lcl_hit(reg_addr, OFF_MASK_CLR))
    begin
      nxt_mask = mask_ff & ~reg_wdata;
    end
    else if (reg_wr && lcl_hit(reg_addr, OFF_AUTO))
    begin
      nxt_auto = reg_wdata & CAUSE_IMPL;
    end
    else if (reg_wr && lcl_hit(reg_addr, OFF_TX_INTERRUPT_DELAY_TIMER))
    begin
      nxt_tx_interrupt_delay_timer_cfg = reg_wdata[15:0];
    end
    else if (reg_wr && lcl_hit(reg_addr, OFF_TX_ABSOLUTE_DELAY_TIMER))
    begin
      nxt_tx_absolute_delay_timer_cfg = reg_wdata[15:0];
    end

    if (cpu_vector_clr)
    begin
      nxt_cause = nxt_cause & ~VEC_CLR;                 // [R9]
    end

    // Events last, so a set in the clearing cycle wins
    nxt_cause = (nxt_cause | ev) & CAUSE_IMPL;          // [R1] [R20]
    // Pending and interrupt track the next cause and mask together
    nxt_pend  = |(nxt_cause & nxt_mask);                // [R2] [R8] [R21]
    nxt_irq   = nxt_pend & pci_int_en;                  // [R19]
  end

  // Register file flops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cause_ff    <= CAUSE_RST;
      mask_ff     <= MASK_RST;
      auto_ff     <= AUTO_RST;
      tx_interrupt_delay_timer_cfg_ff <= DELAY_RST;
      tx_absolute_delay_timer_cfg_ff <= DELAY_RST;
      pend_ff     <= 1'b0;
      irq_ff      <= 1'b0;
      rdata_ff    <= ZERO32;
    end
    else if (ce)
    begin
      cause_ff    <= nxt_cause;
      mask_ff     <= nxt_mask;
      auto_ff     <= nxt_auto;
      tx_interrupt_delay_timer_cfg_ff <= nxt_tx_interrupt_delay_timer_cfg;
      tx_absolute_delay_timer_cfg_ff <= nxt_tx_absolute_delay_timer_cfg;
      pend_ff     <= nxt_pend;
      irq_ff      <= nxt_irq;
      rdata_ff    <= nxt_rdata;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata    = rdata_ff;
  assign int_asserted = pend_ff;
  assign irq          = irq_ff;

endmodule : lcl_cause_latch

`default_nettype wire

// *** logic/lcl_pkg.sv ***
// Constants, field layouts and carrier types for the interrupt cause latch
package lcl_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int unsigned ADDR_W       = 20;            // Register address width
  localparam logic [19:0] OFF_CAUSE    = 20'h000C0;     // Interrupt cause
  localparam logic [19:0] OFF_MASK     = 20'h000D0;     // Enable mask, read/write
  localparam logic [19:0] OFF_MASK_CLR = 20'h000D8;     // Mask clear, write one
  localparam logic [19:0] OFF_AUTO     = 20'h000E0;     // Auto-mask value
  localparam logic [19:0] OFF_TX_INTERRUPT_DELAY_TIMER     = 20'h000E8;     // Tx delay reload
  localparam logic [19:0] OFF_TX_ABSOLUTE_DELAY_TIMER     = 20'h000EC;     // Tx absolute delay

  // ************************************************************
  // Cause bit positions
  // ************************************************************
  localparam int unsigned BIT_TX_DESCRIPTOR_WRITTEN_BACK   = 0;               // Tx descriptor written back
  localparam int unsigned BIT_TX_QUEUE_EMPTY   = 1;               // Tx queue empty
  localparam int unsigned BIT_LSC    = 2;               // Link status change
  localparam int unsigned BIT_RXDMT  = 4;               // Rx descriptor low threshold
  localparam int unsigned BIT_DSW    = 5;               // Sw write disable changed
  localparam int unsigned BIT_RXO    = 6;               // Rx FIFO overrun
  localparam int unsigned BIT_RX_TIMER_EXPIRED   = 7;               // Rx timer expired
  localparam int unsigned BIT_PHY_MGMT_ACCESS_DONE   = 9;               // PHY management done
  localparam int unsigned BIT_PHY_INTERRUPT = 12;              // PHY interrupt
  localparam int unsigned BIT_PEND   = 31;              // Interrupt pending

  // ************************************************************
  // Field masks and reset values
  // ************************************************************
  localparam logic [31:0] CAUSE_IMPL = 32'h000012F7;    // Implemented cause bits
  localparam logic [31:0] VEC_CLR    = 32'h00030080;    // Cleared with cpu vector
  localparam logic [31:0] CAUSE_RST  = 32'h00000000;    // Cause after reset
  localparam logic [31:0] MASK_RST   = 32'h00000000;    // Mask after reset
  localparam logic [31:0] AUTO_RST   = 32'h00000000;    // Auto-mask after reset
  localparam logic [15:0] DELAY_RST  = 16'h0000;        // Delay reloads after reset
  localparam logic [31:0] ZERO32     = 32'h00000000;    // Empty word

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic tx_desc_done;       // Descriptor with report_status_flag done
    logic tx_delay_req;       // Same descriptor had delayed_interrupt_enable
    logic rx_low;             // rx_descriptor_low_threshold reached
    logic sw_dis_ctrl;        // sw_write_disable_control level
    logic rx_overrun;         // rx_fifo_overrun pulse
    logic rx_timer;           // rx_timer_expired pulse
    logic mdio_done;          // phy_mgmt_access_done pulse
  } lcl_evt_t;

  typedef enum logic [1:0] {
    LCL_TX_IDLE = 2'b01,      // No delayed tx interrupt pending
    LCL_TX_WAIT = 2'b10       // Delay timers running
  } lcl_txst_t;

  // Address decode used for every register
  function automatic logic lcl_hit(input logic [19:0] addr, input logic [19:0] off);
    lcl_hit = (addr == off);
  endfunction : lcl_hit

endpackage : lcl_pkg

// *** tb/lcl_cause_latch_properties.sv ***
// Concurrent checks on the ports of the interrupt cause latch
`timescale 1ns/1ps
`default_nettype none

module lcl_cause_latch_properties
  import lcl_pkg::*;
(
  input wire logic              clk,            // MAC clock
  input wire logic              sys_rst,        // Async reset, active high
  input wire logic              ce,             // Clock enable
  input wire logic [ADDR_W-1:0] reg_addr,       // Register byte address
  input wire logic [31:0]       reg_wdata,      // Write data
  input wire logic              reg_wr,         // Write strobe
  input wire logic              reg_rd,         // Read strobe
  input wire logic [31:0]       reg_rdata,      // Read data
  input wire lcl_evt_t          evt,            // Event sources
  input wire logic [1:0]        tx_queue_empty, // Queue empty levels
  input wire logic              cpu_vector_clr, // Vector clear pulse
  input wire logic              pci_int_en,     // Config interrupt enable
  input wire logic              link_up_pin,    // Link pin
  input wire logic              phy_int_n_pin,  // PHY interrupt pin
  input wire logic              int_asserted,   // Pending flag
  input wire logic              irq             // Host interrupt
);
  // ************************************************************
  // Sequences
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Cause register read taken at this edge
  sequence s_cause_rd;
    reg_rd && ce && reg_addr == OFF_CAUSE;
  endsequence

  // Write-one to the overrun bit with no overrun in the same cycle
  sequence s_wr_ovr;
    reg_wr && ce && reg_addr == OFF_CAUSE && reg_wdata[BIT_RXO] && !evt.rx_overrun;
  endsequence

  // An event followed at once by a cause read must show its bit
  property p_sets(ev, b);
    ev && ce ##1 s_cause_rd |=> reg_rdata[b];
  endproperty

  // ************************************************************
  // Assertions
  // ************************************************************
  // Read data only stands in the cycle after a strobe
  chk_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == ZERO32)
    else $error("Read data not zero outside a read");
  chk_rsvd_zero: assert property (s_cause_rd |=> (reg_rdata & ~(CAUSE_IMPL | 32'h80000000)) == ZERO32)
    else $error("Reserved cause bit read as one");
  chk_pend_copy: assert property (s_cause_rd |=> reg_rdata[BIT_PEND] == $past(int_asserted))
    else $error("Pending bit differs from pending flag");
  // Irq follows the pending flag gated by the config enable
  chk_irq_gate: assert property ($past(ce) |-> irq == (int_asserted && $past(pci_int_en)))
    else $error("Interrupt output not pending and enable");
  chk_ovr_sets: assert property (p_sets(evt.rx_overrun, BIT_RXO))
    else $error("Overrun event missing from cause read");
  chk_mdio_sets: assert property (p_sets(evt.mdio_done, BIT_PHY_MGMT_ACCESS_DONE))
    else $error("Management done missing from cause read");
  chk_rxlow_sets: assert property (p_sets(evt.rx_low, BIT_RXDMT))
    else $error("Descriptor low missing from cause read");
  chk_txdone_sets: assert property (p_sets(evt.tx_desc_done && !evt.tx_delay_req, BIT_TX_DESCRIPTOR_WRITTEN_BACK))
    else $error("Tx done missing from cause read");
  // Vector clear wins unless the timer fires in the same cycle
  chk_vec_clear: assert property (cpu_vector_clr && ce && !evt.rx_timer ##1 s_cause_rd |=> !reg_rdata[BIT_RX_TIMER_EXPIRED])
    else $error("Timer bit survived vector clear");
  chk_wr_clear: assert property (s_wr_ovr ##1 s_cause_rd |=> !reg_rdata[BIT_RXO])
    else $error("Overrun bit survived write one");
endmodule : lcl_cause_latch_properties

bind lcl_cause_latch lcl_cause_latch_properties i_chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .tx_queue_empty(tx_queue_empty),
  .cpu_vector_clr(cpu_vector_clr), .pci_int_en(pci_int_en), .link_up_pin(link_up_pin),
  .phy_int_n_pin(phy_int_n_pin), .int_asserted(int_asserted), .irq(irq)
);

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the interrupt cause latch
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
  begin \
    checked++; \
    if ((act) !== (exp)) \
    begin \
      error_cnt++; \
      $display("Error at %0t ns: got %h expected %h", $time, act, exp); \
    end \
  end

module tb
  import lcl_pkg::*;
;
  logic              clk            = 1'b0;   // 40 MHz clock
  logic              sys_rst        = 1'b1;   // Held for two cycles
  logic [ADDR_W-1:0] reg_addr       = '0;     // Bus address
  logic [31:0]       reg_wdata      = '0;     // Bus write data
  logic              reg_wr         = 1'b0;   // Write strobe
  logic              reg_rd         = 1'b0;   // Read strobe
  logic [31:0]       reg_rdata;               // Read data
  lcl_evt_t          evt            = '0;     // Event sources
  logic [1:0]        tx_queue_empty = 2'b00;  // Queue empty levels
  logic              cpu_vector_clr = 1'b0;   // Vector clear
  logic              pci_int_en     = 1'b0;   // Config enable
  logic              ce             = 1'b1;   // Clock enable, dropped once to check freezing
  logic              link_up_pin    = 1'b0;   // Idle matches sync reset
  logic              phy_int_n_pin  = 1'b1;   // Idle high
  logic              int_asserted;            // Pending flag
  logic              irq;                     // Host interrupt
  int                error_cnt      = 0;      // Mismatches
  int                checked        = 0;      // Comparisons
  logic [31:0]       exp_q[$];                // Expected read data, oldest first
  logic [31:0]       exp_v;                   // Note taken off the queue
  logic              rd_d           = 1'b0;   // Read taken at last edge
  logic              sw_lvl         = 1'b0;   // Write-disable control level
  logic [31:0]       r;                       // Random word
  int                n;                       // Random delay count
  logic [19:0]       addrs[7] = '{OFF_CAUSE, OFF_MASK, OFF_MASK_CLR, OFF_AUTO, OFF_TX_INTERRUPT_DELAY_TIMER, OFF_TX_ABSOLUTE_DELAY_TIMER, 20'h00100};
  logic [6:0]        ev_t[7]  = '{7'h40, 7'h10, 7'h04, 7'h02, 7'h01, 7'h00, 7'h00};
  logic [1:0]        q_t[7]   = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b10};
  logic [31:0]       exp_t[7] = '{32'h1, 32'h10, 32'h40, 32'h80, 32'h200, 32'h2, 32'h2};

  // Clock enable is driven so that a frozen cycle can be shown to lose its event
  lcl_cause_latch i_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .tx_queue_empty(tx_queue_empty),
    .cpu_vector_clr(cpu_vector_clr), .pci_int_en(pci_int_en), .link_up_pin(link_up_pin),
    .phy_int_n_pin(phy_int_n_pin), .int_asserted(int_asserted), .irq(irq)
  );

  // Half period toggle
  always #12.5 clk = ~clk;

  // ************************************************************
  // Drivers
  // ************************************************************
  // One bus cycle; every bus and event input is assigned once so calls may run back to back
  task automatic cyc(input logic w, input logic rr, input logic [19:0] a, input logic [31:0] d,
                     input logic [6:0] e = 7'h00, input logic [1:0] q = 2'b00, input logic v = 1'b0);
    reg_wr <= w;
    reg_rd <= rr;
    reg_addr <= a;
    reg_wdata <= d;
    evt <= lcl_evt_t'(e | {3'h0, sw_lvl, 3'h0});
    tx_queue_empty <= q;
    cpu_vector_clr <= v;
    @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask : wr

  // Note the expectation, then issue the read
  task automatic rd(input logic [19:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    cyc(1'b0, 1'b1, a, ZERO32);
  endtask : rd

  task automatic ev(input logic [6:0] e, input logic [1:0] q = 2'b00, input logic v = 1'b0);
    cyc(1'b0, 1'b0, 20'h00000, ZERO32, e, q, v);
  endtask : ev

  task automatic idle(input int k);
    repeat (k) ev(7'h00);
  endtask : idle

  // Let the edge's updates land before looking
  task automatic chk_int(input logic ia, input logic iq);
    #1;
    `CHK(int_asserted, ia)
    `CHK(irq, iq)
  endtask : chk_int

  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Read data appears one edge after the strobe edge
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
    rd_d <= reg_rd;
  end

  // Watchdog, well beyond the 120 or so cycles needed
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    void'($urandom(71));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (addrs[i]) rd(addrs[i], ZERO32);
    // Mask holds implemented bits only; clear register knocks bits out
    r = $urandom();
    wr(OFF_MASK, r);
    wr(OFF_MASK_CLR, r & 32'h0000FF00);
    rd(OFF_MASK, r & ~32'h0000FF00 & CAUSE_IMPL);
    wr(OFF_TX_INTERRUPT_DELAY_TIMER, ~r);
    rd(OFF_TX_INTERRUPT_DELAY_TIMER, {16'h0000, ~r[15:0]});
    wr(20'h00104, r);
    rd(20'h00104, ZERO32);
    wr(OFF_MASK, ZERO32);
    // Zero mask: every event reads back, then the read has cleared it
    for (int i = 0; i < 7; i++)
    begin
      ev(ev_t[i], q_t[i]);
      rd(OFF_CAUSE, exp_t[i]);
      rd(OFF_CAUSE, ZERO32);
    end
    // Both edges of the link and write-disable levels count, holding does not; only the PHY pin's falling edge counts
    for (int i = 0; i < 2; i++)
    begin
      sw_lvl = ~sw_lvl;
      idle(1);
      rd(OFF_CAUSE, 32'h00000020);
      rd(OFF_CAUSE, ZERO32);
      link_up_pin <= ~link_up_pin;
      phy_int_n_pin <= i[0];
      idle(4);
      rd(OFF_CAUSE, i ? 32'h00000004 : 32'h00001004);
      rd(OFF_CAUSE, ZERO32);
    end
    // Masked source is latched but quiet and survives reads
    pci_int_en <= 1'b1;
    wr(OFF_MASK, 32'h00000240);
    wr(OFF_AUTO, 32'h00000200);
    ev(7'h10);
    chk_int(1'b0, 1'b0);
    rd(OFF_CAUSE, 32'h00000010);
    rd(OFF_CAUSE, 32'h00000010);
    ev(7'h04);
    chk_int(1'b1, 1'b1);
    rd(OFF_CAUSE, 32'h80000050);
    chk_int(1'b0, 1'b0);
    rd(OFF_CAUSE, ZERO32);
    rd(OFF_MASK, 32'h00000040);
    ev(7'h01);
    chk_int(1'b0, 1'b0);
    rd(OFF_CAUSE, 32'h00000200);
    wr(OFF_CAUSE, 32'h80000010);
    rd(OFF_CAUSE, 32'h00000200);
    wr(OFF_CAUSE, 32'h00000200);
    rd(OFF_CAUSE, ZERO32);
    // Pending flag ignores its own bit and drops when the source clears
    ev(7'h04);
    wr(OFF_CAUSE, 32'h80000000);
    chk_int(1'b1, 1'b1);
    pci_int_en <= 1'b0;
    wr(OFF_CAUSE, 32'h00000040);
    chk_int(1'b0, 1'b0);
    ev(7'h04);
    chk_int(1'b1, 1'b0);
    wr(OFF_CAUSE, 32'h00000040);
    rd(OFF_CAUSE, ZERO32);
    pci_int_en <= 1'b1;
    ev(7'h02);
    ev(7'h00, 2'b00, 1'b1);
    rd(OFF_CAUSE, ZERO32);
    // Delayed tx completion fires when the shorter timer runs out
    n = 2 + ($urandom() % 8);
    wr(OFF_TX_INTERRUPT_DELAY_TIMER, n);
    wr(OFF_TX_ABSOLUTE_DELAY_TIMER, 32'h00000040);
    wr(OFF_MASK, 32'h00000041);
    wr(OFF_AUTO, ZERO32);
    ev(7'h60);
    // Count reaches zero n edges after loading; bit 0 lands on the edge after that
    idle(n);
    chk_int(1'b0, 1'b0);
    idle(1);
    chk_int(1'b1, 1'b1);
    rd(OFF_CAUSE, 32'h80000001);
    // Another event flushes the waiting completion at once
    ev(7'h60);
    ev(7'h10);
    chk_int(1'b1, 1'b1);
    rd(OFF_CAUSE, 32'h80000011);
    idle(12);
    rd(OFF_CAUSE, ZERO32);
    // A frozen cycle drops its event and leaves the flags alone
    ce <= 1'b0;
    ev(7'h04);
    ce <= 1'b1;
    chk_int(1'b0, 1'b0);
    rd(OFF_CAUSE, ZERO32);
    idle(3);
    end_of_test();
  end
endmodule : tb

`undef CHK
`default_nettype wire
